/* atah_defs.svh */
// Notes on behaviour
// - names ending _n are asserted low; all other signals are asserted high.
// - task_file_select_n goes low for every task file register access.
// - reg_select_addr carries the three-bit register number of each access.
// - task file register values travel on card_data_bus[7:0] only.
// - data transfers use all sixteen bits of card_data_bus.
// - card_irq_in high means the card has an interrupt pending.
// - card_wait_ready_in high means the card can complete the access.
// - card_hw_reset_n low holds the card in reset.
// - card_read_strobe_n pulses low once for each read access.
// - card_write_strobe_n pulses low once for each write access.
// - card_present_n is watched to learn whether a card is inserted.
// - card_xfer_ack_n goes low to answer a card DMA request.
`ifndef ATAH_DEFS_SVH
`define ATAH_DEFS_SVH
`define ATAH_SETUP_NS 30
`define ATAH_SETUP_CYC ((`ATAH_SETUP_NS + 9) / 10)
`define ATAH_STROBE_NS 70
`define ATAH_STROBE_CYC ((`ATAH_STROBE_NS + 9) / 10)
`define ATAH_HOLD_NS 20
`define ATAH_HOLD_CYC ((`ATAH_HOLD_NS + 9) / 10)
`define ATAH_RESET_NS 25000
`define ATAH_RESET_CYC ((`ATAH_RESET_NS + 9) / 10)
`define ATAH_FIFO_DEPTH 8
`define ATAH_DATA_W 16
`endif

/* atah_pkg.sv */
package atah_pkg;
   typedef enum logic [2:0] {
      ATAH_IDLE = 3'b000,
      ATAH_SETUP = 3'b001,
      ATAH_STROBE = 3'b010,
      ATAH_HOLD = 3'b011,
      ATAH_RESET = 3'b100
   } atah_state_t;
endpackage : atah_pkg

/* atah_fifo.sv */
`timescale 1ns/1ps
module atah_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule : atah_fifo

/* atah_host_port.sv */
`timescale 1ns/1ps
`include "atah_defs.svh"
module atah_host_port #(
   parameter int RESET_CYC = `ATAH_RESET_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   // user command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic cmd_is_data,
   input wire logic [2:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   input wire logic card_reset_req,
   output logic [15:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic card_present,
   output logic card_irq_pending,
   output logic card_xfer_pending,
   input wire logic xfer_ack_req,
   // card pins
   output logic task_file_select_n,
   output logic [2:0] reg_select_addr,
   input wire logic [15:0] card_data_in,
   output logic [15:0] card_data_out,
   output logic card_data_oe,
   input wire logic card_irq_in,
   input wire logic card_wait_ready_in,
   output logic card_hw_reset_n,
   output logic card_read_strobe_n,
   output logic card_write_strobe_n,
   input wire logic card_present_n,
   input wire logic card_xfer_request,
   output logic card_xfer_ack_n
);
   import atah_pkg::*;

   localparam logic [7:0] SETUP_CYC = 8'(`ATAH_SETUP_CYC);
   localparam logic [7:0] STROBE_CYC = 8'(`ATAH_STROBE_CYC);
   localparam logic [7:0] HOLD_CYC = 8'(`ATAH_HOLD_CYC);
   localparam logic [15:0] RST_CYC = 16'(RESET_CYC);

   atah_state_t state_reg;
   logic [7:0] tmr_reg;
   logic [15:0] rst_tmr_reg;
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [15:0] din1_reg;
   logic [15:0] din2_reg;
   logic wr_reg;
   logic data_reg;
   logic [15:0] cap_data;
   logic cap_valid;
   logic cap_ready;
   logic ready_s;

   // shared by the setup, strobe and hold phases so the end points stay identical
   function automatic logic tmr_done(input logic [7:0] cnt, input logic [7:0] lim);
      return cnt >= lim - 8'h01;
   endfunction : tmr_done

   // every pin input passes two flops before use
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 5'h1;
         sync2_reg <= 5'h1;
         din1_reg <= 16'h0000;
         din2_reg <= 16'h0000;
      end else begin
         sync1_reg <= {card_xfer_request, card_irq_in, card_wait_ready_in, 1'b0, card_present_n};
         sync2_reg <= sync1_reg;
         din1_reg <= card_data_in;
         din2_reg <= din1_reg;
      end
   end

   assign ready_s = sync2_reg[2];
   assign card_present = !sync2_reg[0];
   assign card_irq_pending = sync2_reg[3];
   assign card_xfer_pending = sync2_reg[4];

   // dma acknowledge only while the card still asks for it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         card_xfer_ack_n <= 1'b1;
      end else begin
         card_xfer_ack_n <= !(xfer_ack_req && sync2_reg[4]);
      end
   end

   assign cmd_ready = (state_reg == ATAH_IDLE) && !card_reset_req;

   // access sequencer; the strobe waits on ready, so a card that never
   // raises ready stalls the port until rst_n is asserted, since card_reset_req is only taken in idle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ATAH_RESET;
         tmr_reg <= 8'h00;
         rst_tmr_reg <= 16'h0000;
         wr_reg <= 1'b0;
         data_reg <= 1'b0;
         task_file_select_n <= 1'b1;
         reg_select_addr <= 3'h0;
         card_data_out <= 16'h0000;
         card_data_oe <= 1'b0;
         card_read_strobe_n <= 1'b1;
         card_write_strobe_n <= 1'b1;
         card_hw_reset_n <= 1'b0;
      end else begin
         unique case (state_reg)
            ATAH_RESET: begin
               card_hw_reset_n <= 1'b0;
               if (rst_tmr_reg >= RST_CYC - 16'h0001) begin
                  rst_tmr_reg <= 16'h0000;
                  card_hw_reset_n <= 1'b1;
                  state_reg <= ATAH_IDLE;
               end else begin
                  rst_tmr_reg <= rst_tmr_reg + 16'h0001;
               end
            end
            ATAH_IDLE: begin
               task_file_select_n <= 1'b1;
               card_data_oe <= 1'b0;
               if (card_reset_req) begin
                  // drop the card reset at once so a requested pulse is as long as the power-up one
                  card_hw_reset_n <= 1'b0;
                  state_reg <= ATAH_RESET;
               end else if (cmd_valid) begin
                  wr_reg <= cmd_write;
                  data_reg <= cmd_is_data;
                  task_file_select_n <= 1'b0;
                  reg_select_addr <= cmd_addr;
                  // register writes carry the low byte, with the upper byte driven to zero
                  card_data_out <= cmd_is_data ? cmd_wdata : {8'h00, cmd_wdata[7:0]};
                  card_data_oe <= cmd_write;
                  tmr_reg <= 8'h00;
                  state_reg <= ATAH_SETUP;
               end
            end
            ATAH_SETUP: begin
               if (tmr_done(tmr_reg, SETUP_CYC)) begin
                  tmr_reg <= 8'h00;
                  card_read_strobe_n <= wr_reg;
                  card_write_strobe_n <= !wr_reg;
                  state_reg <= ATAH_STROBE;
               end else begin
                  tmr_reg <= tmr_reg + 8'h01;
               end
            end
            ATAH_STROBE: begin
               if (!tmr_done(tmr_reg, STROBE_CYC)) begin
                  tmr_reg <= tmr_reg + 8'h01;
               end else if (ready_s && (wr_reg || cap_ready)) begin
                  tmr_reg <= 8'h00;
                  card_read_strobe_n <= 1'b1;
                  card_write_strobe_n <= 1'b1;
                  state_reg <= ATAH_HOLD;
               end
            end
            ATAH_HOLD: begin
               if (tmr_done(tmr_reg, HOLD_CYC)) begin
                  tmr_reg <= 8'h00;
                  task_file_select_n <= 1'b1;
                  card_data_oe <= 1'b0;
                  state_reg <= ATAH_IDLE;
               end else begin
                  tmr_reg <= tmr_reg + 8'h01;
               end
            end
            default: begin
               state_reg <= ATAH_IDLE;
            end
         endcase
      end
   end

   // read data is taken as the strobe is released; fifo back-pressure holds the strobe
   assign cap_valid = (state_reg == ATAH_STROBE) && !wr_reg && ready_s &&
                      tmr_done(tmr_reg, STROBE_CYC);
   assign cap_data = data_reg ? din2_reg : {8'h00, din2_reg[7:0]};

   atah_fifo #(
      .WIDTH(`ATAH_DATA_W),
      .DEPTH(`ATAH_FIFO_DEPTH)
   ) u_rd_fifo (
      .clk(sys_clk),
      .rst_n(rst_n),
      .in_data(cap_data),
      .in_valid(cap_valid),
      .in_ready(cap_ready),
      .out_data(rd_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready)
   );
endmodule : atah_host_port

/* atah_host_port_monitor.sv */
`timescale 1ns/1ps
module atah_host_port_monitor #(
   parameter int RESET_CYC = 4
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic xfer_ack_req,
   input wire logic task_file_select_n,
   input wire logic [2:0] reg_select_addr,
   input wire logic card_data_oe,
   input wire logic card_irq_in,
   input wire logic card_irq_pending,
   input wire logic card_wait_ready_in,
   input wire logic card_hw_reset_n,
   input wire logic card_read_strobe_n,
   input wire logic card_write_strobe_n,
   input wire logic card_xfer_ack_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_sel_fall;
      $fell(task_file_select_n);
   endsequence
   sequence s_strobe_fall;
      $fell(card_read_strobe_n) || $fell(card_write_strobe_n);
   endsequence
   a_take_selects: assert property (cmd_valid && cmd_ready |=> !task_file_select_n)
      else $error("select not asserted after a taken request");
   a_setup_before_strobe: assert property (s_sel_fall |-> ##3 s_strobe_fall)
      else $error("strobe did not follow select by three cycles");
   a_strobe_under_sel: assert property (!card_read_strobe_n || !card_write_strobe_n |-> !task_file_select_n)
      else $error("strobe low without select");
   a_addr_stable: assert property (!task_file_select_n && $past(!task_file_select_n) |-> $stable(reg_select_addr))
      else $error("address moved during an access");
   a_read_min_width: assert property ($fell(card_read_strobe_n) |-> !card_read_strobe_n [*7])
      else $error("read strobe shorter than seven cycles");
   a_write_drives_bus: assert property (!card_write_strobe_n |-> card_data_oe && card_read_strobe_n)
      else $error("write strobe without bus drive");
   a_read_floats_bus: assert property (!card_read_strobe_n |-> !card_data_oe)
      else $error("bus driven during a read");
   a_wait_holds_strobe: assert property (!card_wait_ready_in [*3] ##0 !card_read_strobe_n |=> !card_read_strobe_n)
      else $error("strobe released while card not ready");
   a_irq_follows: assert property (card_irq_in [*4] |=> card_irq_pending)
      else $error("card interrupt not reported");
   a_card_reset_len: assert property ($rose(rst_n) |-> !card_hw_reset_n [*4])
      else $error("card reset released too early");
   a_ack_on_req: assert property (!card_xfer_ack_n |-> $past(xfer_ack_req))
      else $error("transfer acknowledge without request");
   // counts low cycles of the card reset so both power-up and requested pulses are measured
   int low_cnt;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= card_hw_reset_n ? 0 : low_cnt + 1;
      end
   end
   a_reset_pulse_len: assert property ($rose(card_hw_reset_n) |-> low_cnt == RESET_CYC)
      else $error("card reset pulse length wrong");
endmodule : atah_host_port_monitor
bind atah_host_port atah_host_port_monitor #(.RESET_CYC(RESET_CYC)) u_mon (.sys_clk, .rst_n, .cmd_valid,
   .cmd_ready, .xfer_ack_req, .task_file_select_n, .reg_select_addr, .card_data_oe, .card_irq_in,
   .card_irq_pending, .card_wait_ready_in, .card_hw_reset_n, .card_read_strobe_n, .card_write_strobe_n,
   .card_xfer_ack_n);

/* atah_card_model.sv */
`timescale 1ns/1ps
module atah_card_model (
   input wire logic sys_clk,
   input wire logic task_file_select_n,
   input wire logic [2:0] reg_select_addr,
   input wire logic card_read_strobe_n,
   input wire logic card_write_strobe_n,
   input wire logic card_data_oe,
   input wire logic [15:0] card_data_out,
   input wire logic slow,
   output logic [15:0] card_data_in,
   output logic card_wait_ready_in
);
   logic [15:0] mem [8];
   int cnt = 0;
   wire act = !(card_read_strobe_n && card_write_strobe_n);
   // pull-downs make a released bus read zero, never the last value
   assign card_data_in = card_data_oe ? card_data_out :
      (!card_read_strobe_n && !task_file_select_n) ?
      // upper lane left noisy on reads of registers 1 to 7 so the host's masking is exercised
      ((reg_select_addr == 3'h0) ? mem[0] : {8'h5A, mem[reg_select_addr][7:0]}) : 16'h0000;
   // pulled up when idle; a slow card holds ready low for the first 12 cycles of each strobe
   assign card_wait_ready_in = !(slow && act && cnt < 12);
   always @(posedge sys_clk) begin
      cnt <= act ? cnt + 1 : 0;
      if (!card_write_strobe_n && !task_file_select_n) mem[reg_select_addr] <= card_data_out;
   end
endmodule : atah_card_model

/* atah_host_port_tb_top.sv */
`timescale 1ns/1ps
module atah_host_port_tb_top;
   logic sys_clk, rst_n = 0, cmd_valid = 0, cmd_write = 0, cmd_is_data = 0, card_reset_req = 0, rd_ready = 0;
   logic card_irq_in = 0, card_present_n = 1, card_xfer_request = 0, xfer_ack_req = 0, slow = 0;
   logic [2:0] cmd_addr = 0, reg_select_addr;
   logic [15:0] cmd_wdata = 0, rd_data, card_data_in, card_data_out;
   logic cmd_ready, rd_valid, card_present, card_irq_pending, card_xfer_pending, task_file_select_n;
   logic card_data_oe, card_wait_ready_in, card_hw_reset_n, card_read_strobe_n, card_write_strobe_n;
   logic card_xfer_ack_n;
   int failures = 0, num_checks = 0;
   atah_host_port #(.RESET_CYC(4)) DUT (.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_write, .cmd_is_data,
      .cmd_addr, .cmd_wdata, .card_reset_req, .rd_data, .rd_valid, .rd_ready, .card_present, .card_irq_pending,
      .card_xfer_pending, .xfer_ack_req, .task_file_select_n, .reg_select_addr, .card_data_in, .card_data_out,
      .card_data_oe, .card_irq_in, .card_wait_ready_in, .card_hw_reset_n, .card_read_strobe_n,
      .card_write_strobe_n, .card_present_n, .card_xfer_request, .card_xfer_ack_n);
   atah_card_model M (.sys_clk, .task_file_select_n, .reg_select_addr, .card_read_strobe_n,
      .card_write_strobe_n, .card_data_oe, .card_data_out, .slow, .card_data_in, .card_wait_ready_in);
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wait_ready;
      for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) @(posedge sys_clk) #1;
      if (cmd_ready !== 1'b1) failures++;
   endtask : wait_ready
   task issue(input logic w, input logic d, input logic [2:0] a, input logic [15:0] v);
      wait_ready();
      cmd_write = w;
      cmd_is_data = d;
      cmd_addr = a;
      cmd_wdata = v;
      cmd_valid = 1;
      @(posedge sys_clk) #1 cmd_valid = 0;
   endtask : issue
   task pop(input logic [15:0] e);
      @(posedge sys_clk) #1;
      for (int i = 0; i < 300 && rd_valid !== 1'b1; i++) @(posedge sys_clk) #1;
      if (rd_valid !== 1'b1) failures++;
      chk(rd_data, e);
      rd_ready = 1;
      @(posedge sys_clk) #1 rd_ready = 0;
   endtask : pop
   task t_reset;
      chk(16'(card_hw_reset_n), 16'h0000);
      wait_ready();
      chk(16'(card_hw_reset_n), 16'h0001);
      card_reset_req = 1;
      @(posedge sys_clk) #1 card_reset_req = 0;
      repeat (2) @(posedge sys_clk) #1;
      chk(16'(card_hw_reset_n), 16'h0000);
   endtask : t_reset
   task t_regs;
      for (int a = 0; a < 8; a++) begin
         slow = a[0];
         issue(1, 0, 3'(a), {8'hA5, 8'h30 + 8'(a)});
      end
      issue(1, 1, 3'h0, 16'hBE12);
      for (int a = 0; a < 8; a++) begin
         slow = a[0];
         issue(0, a == 0, 3'(a), 16'h0000);
      end
      issue(0, 0, 3'h1, 16'h0000);
      // ninth read finds the read buffer full, so its strobe must stay down
      repeat (30) @(posedge sys_clk) #1;
      chk(16'(card_read_strobe_n), 16'h0000);
      chk(M.mem[1], 16'h0031);
      pop(16'hBE12);
      for (int a = 1; a < 8; a++) pop(16'h0030 + 16'(a));
      pop(16'h0031);
   endtask : t_regs
   task t_pins;
      card_irq_in = 1;
      card_present_n = 0;
      card_xfer_request = 1;
      xfer_ack_req = 1;
      repeat (6) @(posedge sys_clk) #1;
      chk(16'({card_irq_pending, card_present, card_xfer_pending, card_xfer_ack_n}), 16'h000E);
      card_irq_in = 0;
      card_present_n = 1;
      card_xfer_request = 0;
      repeat (6) @(posedge sys_clk) #1;
      chk(16'({card_irq_pending, card_present, card_xfer_pending, card_xfer_ack_n}), 16'h0001);
      xfer_ack_req = 0;
   endtask : t_pins
   task wrap_up;
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      #16 rst_n = 1;
      t_reset();
      t_regs();
      t_pins();
      wrap_up();
   end
   initial begin
      #100000 failures++;
      wrap_up();
   end
endmodule : atah_host_port_tb_top
